// >>> rtl/i2crap_pkg.sv
package i2crap_pkg;
  // bus addresses by strap: gnd, vdd, data, clock
  localparam logic [6:0] ADDR_STRAP_GND = 7'h48;
  localparam logic [6:0] ADDR_STRAP_VDD = 7'h49;
  localparam logic [6:0] ADDR_STRAP_SDA = 7'h4a;
  localparam logic [6:0] ADDR_STRAP_SCL = 7'h4b;
  // strap codes
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VDD = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_SCL = 2'h3;
  // register pointers
  localparam logic [1:0] PTR_CONVERSION = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] CONVERSION_RESET = 16'h0000;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SDA_HOLD_NS = 100;
  localparam int SDA_HOLD_CYC = (SDA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_HALF_CYC = 32;
  typedef enum logic [2:0] {
    I2CRAP_IDLE = 3'b000,
    I2CRAP_ADDR = 3'b001,
    I2CRAP_PTR = 3'b010,
    I2CRAP_WR = 3'b011,
    I2CRAP_RD = 3'b100,
    I2CRAP_SKIP = 3'b101
  } i2crap_state_type;
endpackage

// >>> rtl/i2crap_if.sv
`timescale 1ns/100ps
interface i2crap_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic scl_in;
  logic sda_in;
  // open-drain wired-and with pull-ups
  assign scl_in = scl_oe_n ? 1'b1 : scl_o;
  assign sda_in = (sda_host_oe_n ? 1'b1 : sda_host_o) & (sda_dev_oe_n ? 1'b1 : sda_dev_o);
  modport dev (input scl_in, input sda_in, output sda_dev_o, output sda_dev_oe_n);
  modport host (input scl_in, input sda_in, output scl_o, output scl_oe_n,
    output sda_host_o, output sda_host_oe_n);
endinterface

// >>> rtl/i2crap_dev.sv
`timescale 1ns/100ps
// Function
// - device never drives the clock line
// - controller makes clock; device only samples
// - oversampled clock works at bus rates well below the reference clock
// - strap pin picks one of four addresses
// - controller holds data steady after clock fall
// - transactions framed by start and stop
// - write: address, pointer, data msb then lsb
// - pointer zero conversion, one configuration
// - pointer-only write just moves the pointer
// - read returns pointed register msb first
module i2crap_dev
  import i2crap_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  // serial link
  i2crap_if.dev LINK,
  // strap and converter side
  input wire logic [1:0] ADDR_STRAP_IN,
  input wire logic [15:0] CONV_DATA_IN,
  input wire logic CONV_VALID_IN,
  output logic [15:0] CONFIG_OUT,
  output logic [15:0] CONVERSION_OUT,
  output logic [1:0] POINTER_OUT
);
  import i2crap_pkg::*;

  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  logic [2:0] sda_dly_r;
  logic [1:0] strap_s1_r, strap_s2_r;
  logic scl_rise, scl_fall, start_det, stop_det, sda_late;
  i2crap_state_type state_r, state_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic ack_r, ack_nxt, rdack_r, rdack_nxt, hi_r, hi_nxt;
  logic [1:0] ptr_r, ptr_nxt;
  logic [7:0] wmsb_r, wmsb_nxt;
  logic [15:0] cfg_r, cfg_nxt, conv_r, conv_nxt, rd_r, rd_nxt;
  logic sda_o_r, sda_o_nxt;
  logic [6:0] my_addr;
  logic [7:0] sh_in;

  // two-flop sync; data delayed so late edges after clock fall settle
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
      sda_dly_r <= 3'h7;
      strap_s1_r <= STRAP_GND;
      strap_s2_r <= STRAP_GND;
    end else begin
      scl_s1_r <= LINK.scl_in;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= LINK.sda_in;
      sda_s2_r <= sda_s1_r;
      sda_dly_r <= {sda_dly_r[1:0], sda_s2_r};
      sda_d_r <= sda_late;
      strap_s1_r <= ADDR_STRAP_IN;
      strap_s2_r <= strap_s1_r;
    end
  end

  assign sda_late = sda_dly_r[2];
  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_late;
  assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_late;

  // address from strap, data-strap relies on controller hold time
  always_comb begin
    case (strap_s2_r)
      STRAP_GND: my_addr = ADDR_STRAP_GND;
      STRAP_VDD: my_addr = ADDR_STRAP_VDD;
      STRAP_SDA: my_addr = ADDR_STRAP_SDA;
      STRAP_SCL: my_addr = ADDR_STRAP_SCL;
      default: my_addr = ADDR_STRAP_GND;
    endcase
  end

  assign sh_in = {sh_r[6:0], sda_late};

  always_comb begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ack_nxt = ack_r;
    rdack_nxt = rdack_r;
    hi_nxt = hi_r;
    ptr_nxt = ptr_r;
    wmsb_nxt = wmsb_r;
    cfg_nxt = cfg_r;
    conv_nxt = CONV_VALID_IN ? CONV_DATA_IN : conv_r;
    rd_nxt = rd_r;
    sda_o_nxt = sda_o_r;
    if (stop_det) begin
      state_nxt = I2CRAP_IDLE;
      sda_o_nxt = 1'b1;
      ack_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = I2CRAP_ADDR;
      bit_nxt = 4'h0;
      sda_o_nxt = 1'b1;
      ack_nxt = 1'b0;
    end else if (scl_rise && !ack_r && state_r != I2CRAP_IDLE && state_r != I2CRAP_SKIP) begin
      sh_nxt = sh_in;
      bit_nxt = bit_r + 4'h1;
      if (state_r == I2CRAP_RD && bit_r == 4'h8) begin
        rdack_nxt = ~sda_late;
      end
    end else if (scl_fall) begin
      if (ack_r) begin
        // ack slot over
        ack_nxt = 1'b0;
        sda_o_nxt = 1'b1;
        bit_nxt = 4'h0;
        if (state_r == I2CRAP_RD) begin
          sda_o_nxt = rd_r[15];
          rd_nxt = {rd_r[14:0], 1'b0};
        end
      end else if (state_r == I2CRAP_RD) begin
        if (bit_r == 4'h9) begin
          bit_nxt = 4'h0;
          if (!rdack_r) begin
            state_nxt = I2CRAP_SKIP;
            sda_o_nxt = 1'b1;
          end else begin
            sda_o_nxt = rd_r[15];
            rd_nxt = {rd_r[14:0], 1'b0};
          end
        end else if (bit_r == 4'h8) begin
          sda_o_nxt = 1'b1;
        end else begin
          sda_o_nxt = rd_r[15];
          rd_nxt = {rd_r[14:0], 1'b0};
        end
      end else if (bit_r == 4'h8) begin
        case (state_r)
          I2CRAP_ADDR: begin
            if (sh_r[7:1] == my_addr) begin
              ack_nxt = 1'b1;
              sda_o_nxt = 1'b0;
              if (sh_r[0]) begin
                state_nxt = I2CRAP_RD;
                rd_nxt = (ptr_r == PTR_CONFIG) ? cfg_r : conv_r;
              end else begin
                state_nxt = I2CRAP_PTR;
              end
            end else begin
              state_nxt = I2CRAP_SKIP;
            end
          end
          I2CRAP_PTR: begin
            ack_nxt = 1'b1;
            sda_o_nxt = 1'b0;
            ptr_nxt = sh_r[1:0];
            state_nxt = I2CRAP_WR;
            hi_nxt = 1'b1;
          end
          I2CRAP_WR: begin
            ack_nxt = 1'b1;
            sda_o_nxt = 1'b0;
            hi_nxt = ~hi_r;
            if (hi_r) begin
              wmsb_nxt = sh_r;
            end else if (ptr_r == PTR_CONFIG) begin
              cfg_nxt = {wmsb_r, sh_r};
            end
          end
          default: state_nxt = I2CRAP_SKIP;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      state_r <= I2CRAP_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
      rdack_r <= 1'b0;
      hi_r <= 1'b1;
      ptr_r <= PTR_CONVERSION;
      wmsb_r <= 8'h00;
      cfg_r <= CONFIG_RESET;
      conv_r <= CONVERSION_RESET;
      rd_r <= 16'h0000;
      sda_o_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ack_r <= ack_nxt;
      rdack_r <= rdack_nxt;
      hi_r <= hi_nxt;
      ptr_r <= ptr_nxt;
      wmsb_r <= wmsb_nxt;
      cfg_r <= cfg_nxt;
      conv_r <= conv_nxt;
      rd_r <= rd_nxt;
      sda_o_r <= sda_o_nxt;
    end
  end

  // open drain: enable low only when pulling low; no clock driver exists
  assign LINK.sda_dev_o = 1'b0;
  assign LINK.sda_dev_oe_n = sda_o_r;
  assign CONFIG_OUT = cfg_r;
  assign CONVERSION_OUT = conv_r;
  assign POINTER_OUT = ptr_r;
endmodule // i2crap_dev

// >>> rtl/i2crap_host.sv
`timescale 1ns/100ps
module i2crap_host
  import i2crap_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  // serial link
  i2crap_if.host LINK,
  // command port
  input wire logic CMD_VALID_IN,
  input wire logic CMD_READ_IN,
  input wire logic [6:0] CMD_ADDR_IN,
  input wire logic [7:0] CMD_PTR_IN,
  input wire logic [1:0] CMD_NDATA_IN,
  input wire logic [15:0] CMD_WDATA_IN,
  output logic CMD_READY_OUT,
  output logic DONE_OUT,
  output logic NACK_OUT,
  output logic [15:0] RDATA_OUT
);
  import i2crap_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_BIT = 3'b010,
    H_STOP = 3'b011,
    H_END = 3'b100
  } i2crap_hstate_type;

  logic sda_s1_r, sda_s2_r;
  i2crap_hstate_type st_r, st_nxt;
  logic [5:0] div_r, div_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [1:0] byte_r, byte_nxt, nbytes_r, nbytes_nxt;
  logic rd_r, rd_nxt, nack_r, nack_nxt, done_r, done_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic [15:0] wd_r, wd_nxt, rdat_r, rdat_nxt;
  logic scl_r, scl_nxt, sda_r, sda_nxt, tick;
  logic [7:0] next_byte;

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= LINK.sda_in;
      sda_s2_r <= sda_s1_r;
    end
  end

  assign tick = (div_r == 6'(SCL_HALF_CYC - 1));

  // byte sequence: address, pointer, data msb, data lsb
  always_comb begin
    case (byte_r)
      2'h0: next_byte = ptr_r;
      2'h1: next_byte = wd_r[15:8];
      default: next_byte = wd_r[7:0];
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    div_nxt = tick ? 6'h00 : div_r + 6'h01;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    nbytes_nxt = nbytes_r;
    rd_nxt = rd_r;
    nack_nxt = nack_r;
    done_nxt = 1'b0;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    rdat_nxt = rdat_r;
    scl_nxt = scl_r;
    sda_nxt = sda_r;
    case (st_r)
      H_IDLE: begin
        div_nxt = 6'h00;
        if (CMD_VALID_IN) begin
          st_nxt = H_START;
          rd_nxt = CMD_READ_IN;
          addr_nxt = CMD_ADDR_IN;
          ptr_nxt = CMD_PTR_IN;
          wd_nxt = CMD_WDATA_IN;
          nbytes_nxt = CMD_READ_IN ? 2'h2 : CMD_NDATA_IN;
          nack_nxt = 1'b0;
          ph_nxt = 2'h0;
        end
      end
      H_START: if (tick) begin
        // start: data falls while clock high
        sda_nxt = 1'b0;
        st_nxt = H_BIT;
        sh_nxt = {addr_r, rd_r};
        bit_nxt = 4'h0;
        byte_nxt = 2'h0;
        ph_nxt = 2'h0;
      end
      H_BIT: if (tick) begin
        ph_nxt = ph_r + 2'h1;
        case (ph_r)
          2'h0: begin
            scl_nxt = 1'b0;
          end
          2'h1: begin
            if (bit_r < 4'h8) begin
              sda_nxt = rd_r && byte_r != 2'h3 ? 1'b1 : sh_r[7];
            end else begin
              sda_nxt = rd_r && byte_r != 2'h3 ? (byte_r == 2'h1) : 1'b1;
            end
          end
          2'h2: begin
            scl_nxt = 1'b1;
          end
          default: begin
            ph_nxt = 2'h0;
            bit_nxt = bit_r + 4'h1;
            if (bit_r < 4'h8) begin
              sh_nxt = {sh_r[6:0], 1'b0};
              if (rd_r && byte_r != 2'h3) begin
                rdat_nxt = {rdat_r[14:0], sda_s2_r};
              end
            end else begin
              bit_nxt = 4'h0;
              if ((!rd_r || byte_r == 2'h3) && sda_s2_r) begin
                nack_nxt = 1'b1;
                st_nxt = H_STOP;
              end else if (rd_r) begin
                byte_nxt = (byte_r == 2'h3) ? 2'h0 : byte_r + 2'h1;
                if (byte_r == 2'h1) begin
                  st_nxt = H_STOP;
                end
              end else if (byte_r == nbytes_r + 2'h1 || byte_r == 2'h3) begin
                st_nxt = H_STOP;
              end else begin
                sh_nxt = next_byte;
                byte_nxt = byte_r + 2'h1;
              end
              if (rd_r && byte_r == 2'h3) begin
                byte_nxt = 2'h0;
              end
            end
          end
        endcase
      end
      H_STOP: if (tick) begin
        ph_nxt = ph_r + 2'h1;
        case (ph_r)
          2'h0: scl_nxt = 1'b0;
          2'h1: sda_nxt = 1'b0;
          2'h2: scl_nxt = 1'b1;
          default: begin
            sda_nxt = 1'b1;
            st_nxt = H_END;
          end
        endcase
      end
      H_END: if (tick) begin
        st_nxt = H_IDLE;
        done_nxt = 1'b1;
      end
      default: st_nxt = H_IDLE;
    endcase
    // read address byte is marked with byte index three
    if (st_r == H_START && tick && rd_r) begin
      byte_nxt = 2'h3;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN) begin
      st_r <= H_IDLE;
      div_r <= 6'h00;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      nbytes_r <= 2'h0;
      rd_r <= 1'b0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      addr_r <= 7'h00;
      wd_r <= 16'h0000;
      rdat_r <= 16'h0000;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      nbytes_r <= nbytes_nxt;
      rd_r <= rd_nxt;
      nack_r <= nack_nxt;
      done_r <= done_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      rdat_r <= rdat_nxt;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end

  // data changes one quarter period after clock fall, well past hold time
  assign LINK.scl_o = 1'b0;
  assign LINK.scl_oe_n = scl_r;
  assign LINK.sda_host_o = 1'b0;
  assign LINK.sda_host_oe_n = sda_r;
  assign CMD_READY_OUT = (st_r == H_IDLE);
  assign DONE_OUT = done_r;
  assign NACK_OUT = nack_r;
  assign RDATA_OUT = rdat_r;
endmodule // i2crap_host

// >>> tb/i2crap_chk.sv
`timescale 1ns/100ps
module i2crap_chk
  import i2crap_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic NRST_IN,
  // link signals
  input wire logic scl_oe_n,
  input wire logic sda_host_oe_n,
  input wire logic sda_dev_oe_n,
  input wire logic scl_in,
  input wire logic sda_in
);
  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  property p_clk_free;
    scl_oe_n |-> scl_in;
  endproperty
  a_clk_free: assert property (p_clk_free) else $error("clock low while released");
  property p_high_min;
    $rose(scl_in) |=> scl_in [*8];
  endproperty
  a_high_min: assert property (p_high_min) else $error("clock high phase short");
  property p_low_min;
    $fell(scl_in) |=> !scl_in [*8];
  endproperty
  a_low_min: assert property (p_low_min) else $error("clock low phase short");
  property p_start_clk;
    $fell(sda_in) && scl_in && $past(scl_in) |-> ##[1:64] !scl_in;
  endproperty
  a_start_clk: assert property (p_start_clk) else $error("no clock after start");
  property p_stop_idle;
    $rose(sda_in) && scl_in && $past(scl_in) |=> (scl_in && sda_in) [*2];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("bus busy after stop");
  property p_hold;
    $fell(scl_in) |=> $stable(sda_host_oe_n) [*8] ##1 $stable(sda_host_oe_n) [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("data changed too soon");
  property p_dev_edge;
    scl_in && $past(scl_in) |-> $stable(sda_dev_oe_n);
  endproperty
  a_dev_edge: assert property (p_dev_edge) else $error("device data moved");
  // longest legal low: ack slot plus eight zero bits
  localparam int DEV_LOW_MAX = 36 * SCL_HALF_CYC + 8;
  logic [10:0] dev_low_cnt;
  always_ff @(posedge REF_CLK_IN) begin
    if (!NRST_IN || sda_dev_oe_n) begin
      dev_low_cnt <= 11'h000;
    end else if (dev_low_cnt != 11'h7ff) begin
      dev_low_cnt <= dev_low_cnt + 11'h001;
    end
  end
  property p_dev_rel;
    !sda_dev_oe_n |-> dev_low_cnt <= 11'(DEV_LOW_MAX);
  endproperty
  a_dev_rel: assert property (p_dev_rel) else $error("device holds data");
endmodule // i2crap_chk

// >>> tb/tb.sv
`timescale 1ns/100ps
module tb;
  import i2crap_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cv = 1'b0;
  logic rd = 1'b0;
  logic cvld = 1'b0;
  logic [1:0] strap = 2'h0;
  logic [6:0] addr = 7'h48;
  logic [7:0] ptr = 8'h0;
  logic [1:0] nd = 2'h0;
  logic [15:0] wd = 16'h0;
  logic [15:0] cdat = 16'h0;
  logic [15:0] rnd = 16'h58;
  logic rdy, done, nack;
  logic [15:0] rdat, cfg, conv;
  logic [1:0] pout;
  logic [6:0] adr [4] = '{ADDR_STRAP_GND, ADDR_STRAP_VDD, ADDR_STRAP_SDA, ADDR_STRAP_SCL};
  int failures = 0;
  int comparisons = 0;
  int m_cfg = int'(CONFIG_RESET);
  int m_conv = int'(CONVERSION_RESET);
  int m_ptr = 0;
  always #5 clk = ~clk;
  i2crap_if link ();
  i2crap_dev u_i2crap_dev (.REF_CLK_IN(clk), .NRST_IN(nrst), .LINK(link),
    .ADDR_STRAP_IN(strap), .CONV_DATA_IN(cdat), .CONV_VALID_IN(cvld),
    .CONFIG_OUT(cfg), .CONVERSION_OUT(conv), .POINTER_OUT(pout));
  i2crap_host u_i2crap_host (.REF_CLK_IN(clk), .NRST_IN(nrst), .LINK(link),
    .CMD_VALID_IN(cv), .CMD_READ_IN(rd), .CMD_ADDR_IN(addr), .CMD_PTR_IN(ptr),
    .CMD_NDATA_IN(nd), .CMD_WDATA_IN(wd), .CMD_READY_OUT(rdy), .DONE_OUT(done),
    .NACK_OUT(nack), .RDATA_OUT(rdat));
  i2crap_chk u_i2crap_chk (.REF_CLK_IN(clk), .NRST_IN(nrst), .scl_oe_n(link.scl_oe_n),
    .sda_host_oe_n(link.sda_host_oe_n), .sda_dev_oe_n(link.sda_dev_oe_n),
    .scl_in(link.scl_in), .sda_in(link.sda_in));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] m_read();
    return (m_ptr == 1) ? m_cfg[15:0] : m_conv[15:0];
  endfunction
  task automatic report_and_stop();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one whole transaction, entered at a falling edge
  task automatic xfer(input logic r, input logic [6:0] a, input logic [7:0] p,
      input logic [1:0] n, input logic [15:0] d);
    int k;
    k = 0;
    rd = r;
    addr = a;
    ptr = p;
    nd = n;
    wd = d;
    cv = 1'b1;
    while (rdy !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (rdy !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    @(posedge clk);
    @(negedge clk);
    cv = 1'b0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (done !== 1'b1) begin
      failures++;
      report_and_stop();
    end
  endtask
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    xfer(1'b1, adr[0], 8'h0, 2'h0, 16'h0);
    chk(rdat, m_read());
    chk(cfg, m_cfg[15:0]);
    // each strap code, config written then read back
    for (int s = 0; s < 4; s++) begin
      strap = s[1:0];
      rnd = lfsr(rnd);
      xfer(1'b0, adr[s], 8'h1, 2'h2, rnd);
      m_cfg = int'(rnd);
      m_ptr = 1;
      chk({15'h0, nack}, 16'h0);
      chk(cfg, m_cfg[15:0]);
      xfer(1'b1, adr[s], 8'h0, 2'h0, 16'h0);
      chk(rdat, m_read());
    end
    rnd = lfsr(rnd);
    cdat = rnd;
    cvld = 1'b1;
    @(negedge clk);
    cvld = 1'b0;
    m_conv = int'(rnd);
    // pointer-only write, then conversion read
    xfer(1'b0, adr[3], 8'h0, 2'h0, 16'h0);
    m_ptr = 0;
    chk(cfg, m_cfg[15:0]);
    chk({14'h0, pout}, 16'h0);
    xfer(1'b1, adr[3], 8'h0, 2'h0, 16'h0);
    chk(rdat, m_read());
    // data to the read-only result is dropped
    xfer(1'b0, adr[3], 8'h0, 2'h2, ~rnd);
    chk(conv, m_conv[15:0]);
    chk({15'h0, nack}, 16'h0);
    // unused pointer code: data dropped, reads give the result
    xfer(1'b0, adr[3], 8'h3, 2'h2, ~rnd);
    m_ptr = 3;
    chk(cfg, m_cfg[15:0]);
    chk({14'h0, pout}, 16'h3);
    xfer(1'b1, adr[3], 8'h0, 2'h0, 16'h0);
    chk(rdat, m_read());
    // another target's address is ignored
    xfer(1'b0, adr[0], 8'h1, 2'h2, ~rnd);
    chk({15'h0, nack}, 16'h1);
    chk(cfg, m_cfg[15:0]);
    report_and_stop();
  end
endmodule // tb
